// File: pkg/prescaler_if.sv
// carrier between the prescaler control and the tick divider
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface prescaler_if;
   logic [3:0] code_low;
   logic [3:0] code_high;
   logic       timer_tick;
   logic       tick_low;
   logic       tick_high;

   modport ctrl (output code_low, output code_high, output timer_tick,
                 input tick_low, input tick_high);
   modport div  (input code_low, input code_high, input timer_tick,
                 output tick_low, output tick_high);
endinterface : prescaler_if
`default_nettype wire

// File: pkg/prescaler_pkg.sv
// constants shared by the serial unit clock prescaler and its tick divider
// assumes one system clock (ref_clk, 20 MHz) and software on a plain port
package prescaler_pkg;
   // register port shape, channel count, code and divider widths
   localparam int unsigned ADDR_W    = 3;
   localparam int unsigned DATA_W    = 16;
   localparam int unsigned CH_NUM    = 4;
   localparam int unsigned CODE_W    = 4;
   localparam int unsigned DIV_W     = 11;

   // register offsets on the plain port
   localparam logic [2:0] PRESCALE_OFS = 3'h0;
   localparam logic [2:0] CKSRC_OFS    = 3'h1;
   localparam logic [2:0] START_OFS    = 3'h2;
   localparam logic [2:0] STOP_OFS     = 3'h3;
   localparam logic [2:0] STATUS_OFS   = 3'h4;
   localparam logic [2:0] CLKOUT_OFS   = 3'h5;
   localparam logic [2:0] FAULT_OFS    = 3'h6;

   // divider code meaning
   localparam logic [3:0] CODE_DIV_MAX = 4'hB;
   localparam logic [3:0] CODE_TIMER   = 4'hF;

   // values after reset
   localparam logic [7:0]  PRESCALE_RST = 8'h00;
   localparam logic [3:0]  CKSRC_RST    = 4'h0;
   localparam logic [3:0]  RUN_RST      = 4'h0;
   localparam logic [3:0]  CLKOUT_RST   = 4'hF;
   localparam logic [10:0] DIV_CNT_RST  = 11'h000;
endpackage : prescaler_pkg

// File: tb/test_serial_unit_clock_prescaler.sv
// self-checking bench for the serial unit clock prescaler
// assumes unit 0 defaults and the plain register port of the package
`timescale 1ns/100ps
`default_nettype none
module test_serial_unit_clock_prescaler;
   import prescaler_pkg::*;
   logic              ref_clk;
   logic              rst;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic              timer2_tick_pulse;
   logic [CH_NUM-1:0] comm_clk_drive;
   logic [CH_NUM-1:0] operation_clock;
   logic [CH_NUM-1:0] serial_clk_pin;
   logic [CH_NUM-1:0] channel_run_status;
   logic              all_stopped;
   logic              code_fault;
   logic [CH_NUM-1:0] unit2_status;
   logic              unit2_fault;
   logic              rd_seen;
   logic [CH_NUM-1:0] cprev;
   logic [DATA_W-1:0] exp_q [$];
   int                n_fail;
   int                n_compared;
   int                seed;
   int                ticks [CH_NUM];
   int                np;
   int                w;

   serial_unit_clock_prescaler u_dut (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .timer2_tick_pulse(timer2_tick_pulse),
      .comm_clk_drive(comm_clk_drive), .operation_clock(operation_clock),
      .serial_clk_pin(serial_clk_pin),
      .channel_run_status(channel_run_status),
      .all_stopped(all_stopped), .code_fault(code_fault));

   // a unit-2 copy checks the masked status bits and the refused timer code
   serial_unit_clock_prescaler #(.UNIT_INDEX(2)) u_dut_unit2 (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(), .timer2_tick_pulse(timer2_tick_pulse),
      .comm_clk_drive(comm_clk_drive), .operation_clock(),
      .serial_clk_pin(), .channel_run_status(unit2_status),
      .all_stopped(), .code_fault(unit2_fault));

   // 20 MHz system clock
   always #25 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [DATA_W-1:0] exp,
                      input logic [DATA_W-1:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim

   // one-cycle strobes; the task always lets an edge pass before the next
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      exp_q.push_back(e);
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
   endtask : rd

   // ticks are counted at the falling edge, where outputs have settled
   task automatic count(input int cyc);
      for (int c = 0; c < CH_NUM; c++) ticks[c] = 0;
      repeat (cyc) begin
         @(negedge ref_clk);
         for (int c = 0; c < CH_NUM; c++)
            if (operation_clock[c] === 1'b1) ticks[c]++;
      end
   endtask : count

   ////////////////////////////////////////////////////////////////////////
   // read data stand only in the cycle after the strobe, so look there
   always @(posedge ref_clk) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0) chk("unexpected read", 16'h0000, 16'hFFFF);
         else chk("reg_rdata", exp_q.pop_front(), reg_rdata);
      end
      rd_seen <= reg_rd;
   end

   // a hang is cut short and counted as a mismatch
   initial begin
      repeat (50000) @(posedge ref_clk);
      n_fail++;
      $display("test watchdog expired");
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h0A12;
      ref_clk = 1'b0;
      rst = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      timer2_tick_pulse = 1'b0;
      comm_clk_drive = 4'h0;
      n_fail = 0;
      n_compared = 0;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("run status", 16'(RUN_RST), 16'(channel_run_status));
      chk("all_stopped", 16'h0001, 16'(all_stopped));
      chk("pin idle", 16'h000F, 16'(serial_clk_pin));
      @(posedge ref_clk);
      rst <= 1'b0;
      rd(STATUS_OFS, 16'h0000);
      rd(PRESCALE_OFS, 16'h0000);
      rd(CKSRC_OFS, 16'h0000);
      rd(CLKOUT_OFS, 16'h000F);
      rd(3'h7, 16'h0000);
      $display("test reset values done");

      // start and stop, with stray high bits and a write to status
      wr(START_OFS, 16'hFFF5);
      @(negedge ref_clk);
      chk("run status", 16'h0005, 16'(channel_run_status));
      chk("unit2 status", 16'h0001, 16'(unit2_status));
      // idle flag trails the status by one cycle
      @(negedge ref_clk);
      chk("all_stopped", 16'h0000, 16'(all_stopped));
      wr(STATUS_OFS, 16'h000F);
      wr(STOP_OFS, 16'h0001);
      rd(STATUS_OFS, 16'h0004);
      $display("test start stop done");

      // channel 2 runs: its clock-out bit is locked, engine owns the pin
      wr(CLKOUT_OFS, 16'h0000);
      rd(CLKOUT_OFS, 16'h0004);
      repeat (24) begin
         @(posedge ref_clk);
         cprev = comm_clk_drive;
         comm_clk_drive <= 4'($random(seed));
         @(negedge ref_clk);
         chk("pin running", 16'(cprev & 4'h4), 16'(serial_clk_pin));
      end
      wr(STOP_OFS, 16'h0004);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("pin stopped", 16'h0004, 16'(serial_clk_pin));
      $display("test clock pin done");

      // channel 1 takes the high code, channel 0 the low one
      wr(CKSRC_OFS, 16'h0002);
      rd(CKSRC_OFS, 16'h0002);
      for (int k = 0; k <= 11; k++) begin
         wr(PRESCALE_OFS, 16'(((11 - k) << 4) | k));
         repeat (4) @(posedge ref_clk);
         w = 2 << ((k > 11 - k) ? k : 11 - k);
         count(w);
         chk("ticks low", 16'(w >> k), 16'(ticks[0]));
         chk("ticks high", 16'(w >> (11 - k)), 16'(ticks[1]));
      end
      $display("test divider codes done");

      // all-ones code forwards the timer pulse in unit 0
      wr(PRESCALE_OFS, 16'h000F);
      repeat (4) @(posedge ref_clk);
      np = 0;
      fork
         count(72);
         repeat (64) begin
            @(posedge ref_clk);
            w = (($random(seed) & 3) == 0) ? 1 : 0;
            timer2_tick_pulse <= w[0];
            np += w;
         end
      join_any
      @(posedge ref_clk);
      timer2_tick_pulse <= 1'b0; // timer source idle before any change
      wait fork;
      chk("timer ticks", 16'(np), 16'(ticks[2]));
      chk("fault on F", 16'h0000, 16'(code_fault));
      chk("unit2 fault on F", 16'h0001, 16'(unit2_fault));
      $display("test timer source done");

      // prohibited codes give no ticks and raise the sticky fault
      for (int c = 12; c <= 14; c++) begin
         wr(PRESCALE_OFS, 16'(c));
         w = 0;
         while (code_fault !== 1'b1 && w < 8) begin
            @(negedge ref_clk);
            w++;
         end
         chk("code_fault", 16'h0001, 16'(code_fault));
         count(16);
         chk("ticks prohibited", 16'h0000, 16'(ticks[0]));
         wr(PRESCALE_OFS, 16'h0000);
         rd(FAULT_OFS, 16'h0001);
         wr(FAULT_OFS, 16'h0001);
         rd(FAULT_OFS, 16'h0000);
      end
      $display("test prohibited codes done");

      // all four channels stopped before a clock change
      wr(START_OFS, 16'h000F);
      @(negedge ref_clk);
      @(negedge ref_clk);
      chk("all_stopped", 16'h0000, 16'(all_stopped));
      wr(STOP_OFS, 16'h000F);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("all_stopped", 16'h0001, 16'(all_stopped));
      chk("run status", 16'h0000, 16'(channel_run_status));
      repeat (3) @(posedge ref_clk);
      $display("test full stop done");
      end_sim();
   end
endmodule : test_serial_unit_clock_prescaler
`default_nettype wire

// File: verilog/prescale_tick_gen.sv
// power-of-two tick divider for the two prescaler codes
// assumes codes are held steady by software while channels are running
`timescale 1ns/100ps
`default_nettype none
module prescale_tick_gen
   import prescaler_pkg::*;
#(
   parameter bit TIMER_OK = 1'b1
) (
   input  wire logic  ref_clk,
   input  wire logic  rst,
   prescaler_if.div   pif
);

   logic [DIV_W-1:0] div_cnt_reg;

   ////////////////////////////////////////////////////////////////////////
   // free-running count; one counter serves both codes so ticks stay aligned
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         div_cnt_reg <= DIV_CNT_RST;
      end else begin
         div_cnt_reg <= div_cnt_reg + DIV_W'(1);
      end
   end

   // code k gives one tick every 2^k cycles, all ones picks the timer pulse
   function automatic logic tick_for(input logic [3:0] code,
                                     input logic [DIV_W-1:0] cnt,
                                     input logic ttick);
      logic [DIV_W-1:0] mask;
      mask = (DIV_W'(1) << code) - DIV_W'(1);
      if (code <= CODE_DIV_MAX) begin
         tick_for = ((cnt | ~mask) == {DIV_W{1'b1}});
      end else if (code == CODE_TIMER) begin
         tick_for = TIMER_OK & ttick;
      end else begin
         tick_for = 1'b0;
      end
   endfunction : tick_for

   assign pif.tick_low  = tick_for(pif.code_low, div_cnt_reg, pif.timer_tick);
   assign pif.tick_high = tick_for(pif.code_high, div_cnt_reg, pif.timer_tick);

   // code must hold for two cycles, else a rewrite mid-pattern trips it
   a_div_by_two: assert property (@(posedge ref_clk) disable iff (rst)
      (pif.code_low == 4'h1 ##1 pif.code_low == 4'h1)
      |-> pif.tick_low != $past(pif.tick_low))
      else $error("divide-by-two tick pattern broken");

endmodule : prescale_tick_gen
`default_nettype wire

// File: verilog/serial_unit_clock_prescaler.sv
// operation-clock prescaler and channel run status for one serial unit
// assumes a plain register port on ref_clk and protocol engines outside
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - status bit 1 means channel enabled, 0 stopped; unit 2 bits 2,3 invalid
// - channel pick bit selects low or high code; code k divides by 2^k
// - all-ones code picks timer pulse in unit 0; 12-14, and all ones outside unit 0, forbidden
// - unit 0 may run from the timer pulse made off the sub clock
// - start write sets status bits, stop write clears them
// - running channel ignores clock-out bit writes; engine drives the pin
// - reset clears the whole status register
module serial_unit_clock_prescaler
   import prescaler_pkg::*;
#(
   parameter int unsigned UNIT_INDEX = 0
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic              timer2_tick_pulse,
   input  wire logic [CH_NUM-1:0] comm_clk_drive,
   output logic      [CH_NUM-1:0] operation_clock,
   output logic      [CH_NUM-1:0] serial_clk_pin,
   output logic      [CH_NUM-1:0] channel_run_status,
   output logic                   all_stopped,
   output logic                   code_fault
);

   localparam bit TIMER_OK = (UNIT_INDEX == 0);
   // unit 2 only has two channels worth reporting
   localparam logic [3:0] VALID_MASK = (UNIT_INDEX == 2) ? 4'h3 : 4'hF;

   logic [7:0]        prescaler_select_reg;
   logic [3:0]        clock_source_pick_reg;
   logic [3:0]        run_reg;
   logic [3:0]        clkout_reg;
   logic              fault_reg;
   logic              fault_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [3:0]        op_clk_reg;
   logic [3:0]        pin_reg;
   logic              idle_reg;
   logic              wr_start;
   logic              wr_stop;
   logic              wr_fault;
   logic              bad_low;
   logic              bad_high;
   logic              bad_used;

   prescaler_if pif ();

   ////////////////////////////////////////////////////////////////////////
   // tick divider shared by all channels of the unit
   prescale_tick_gen #(
      .TIMER_OK (TIMER_OK)
   ) u_tick (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pif     (pif)
   );

   assign pif.code_low   = prescaler_select_reg[3:0];
   assign pif.code_high  = prescaler_select_reg[7:4];
   // timer pulse arrives from logic on ref_clk, so no synchroniser
   assign pif.timer_tick = timer2_tick_pulse;

   assign wr_start = reg_wr && (reg_addr == START_OFS);
   assign wr_stop  = reg_wr && (reg_addr == STOP_OFS);
   assign wr_fault = reg_wr && (reg_addr == FAULT_OFS);

   ////////////////////////////////////////////////////////////////////////
   // prescaler codes and per-channel source pick
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prescaler_select_reg  <= PRESCALE_RST;
         clock_source_pick_reg <= CKSRC_RST;
      end else if (reg_wr) begin
         if (reg_addr == PRESCALE_OFS) begin
            prescaler_select_reg <= reg_wdata[7:0];
         end
         if (reg_addr == CKSRC_OFS) begin
            clock_source_pick_reg <= reg_wdata[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // run status: start sets, stop clears; strobes never coincide
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run_reg <= RUN_RST;
      end else if (wr_start) begin
         run_reg <= run_reg | reg_wdata[3:0];
      end else if (wr_stop) begin
         run_reg <= run_reg & ~reg_wdata[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock-out bits: only stopped channels take the software value
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clkout_reg <= CLKOUT_RST;
      end else if (reg_wr && (reg_addr == CLKOUT_OFS)) begin
         clkout_reg <= (reg_wdata[3:0] & ~run_reg)
                     | (clkout_reg & run_reg);
      end
   end

   // clock pin: engine drives while running, lets start/stop be hand-made
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_reg <= CLKOUT_RST;
      end else begin
         pin_reg <= (comm_clk_drive & run_reg)
                  | (clkout_reg & ~run_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-channel operation clock tick, one cycle late from the divider
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         op_clk_reg <= 4'h0;
      end else begin
         for (int n = 0; n < CH_NUM; n++) begin
            op_clk_reg[n] <= clock_source_pick_reg[n] ? pif.tick_high
                                                      : pif.tick_low;
         end
      end
   end

   // forbidden code: 12..14 always, all ones outside unit 0
   function automatic logic code_bad(input logic [3:0] code);
      code_bad = (code > CODE_DIV_MAX && code != CODE_TIMER)
               || (code == CODE_TIMER && !TIMER_OK);
   endfunction : code_bad

   assign bad_low  = code_bad(prescaler_select_reg[3:0]);
   assign bad_high = code_bad(prescaler_select_reg[7:4]);
   assign bad_used = |((clock_source_pick_reg & {4{bad_high}})
                     | (~clock_source_pick_reg & {4{bad_low}}));

   ////////////////////////////////////////////////////////////////////////
   // sticky fault for a forbidden code in use; a new event beats the clear
   always_comb begin
      fault_next = fault_reg;
      if (wr_fault && reg_wdata[0]) begin
         fault_next = 1'b0;
      end
      if (bad_used) begin
         fault_next = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fault_reg <= 1'b0;
      end else begin
         fault_reg <= fault_next;
      end
   end

   // idle flag lets software confirm the unit is stopped before a clock swap
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         idle_reg <= 1'b1;
      end else begin
         idle_reg <= (run_reg == 4'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port, data valid in the cycle after the strobe only
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            PRESCALE_OFS: rdata_reg <= {8'h00, prescaler_select_reg};
            CKSRC_OFS:    rdata_reg <= {12'h000, clock_source_pick_reg};
            STATUS_OFS:   rdata_reg <= {12'h000, run_reg & VALID_MASK};
            CLKOUT_OFS:   rdata_reg <= {12'h000, clkout_reg};
            FAULT_OFS:    rdata_reg <= {15'h0, fault_reg};
            default:      rdata_reg <= '0;
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end

   assign reg_rdata          = rdata_reg;
   assign operation_clock    = op_clk_reg;
   assign serial_clk_pin     = pin_reg;
   assign channel_run_status = run_reg & VALID_MASK;
   assign all_stopped        = idle_reg;
   assign code_fault         = fault_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_start_sets: assert property (@(posedge ref_clk) disable iff (rst)
      wr_start |=> ((run_reg & $past(reg_wdata[3:0])) == $past(reg_wdata[3:0])))
      else $error("start write did not set status");

   a_stop_clears: assert property (@(posedge ref_clk) disable iff (rst)
      wr_stop |=> ((run_reg & $past(reg_wdata[3:0])) == 4'h0))
      else $error("stop write did not clear status");

   a_reset_stopped: assert property (@(posedge ref_clk)
      rst |-> (run_reg == 4'h0 && channel_run_status == 4'h0))
      else $error("status not cleared by reset");

   a_status_read: assert property (@(posedge ref_clk) disable iff (rst)
      (reg_rd && reg_addr == STATUS_OFS)
      |=> reg_rdata == {12'h000, $past(run_reg) & VALID_MASK})
      else $error("status read data wrong");

   a_clkout_locked: assert property (@(posedge ref_clk) disable iff (rst)
      (run_reg != 4'h0)
      |=> ((clkout_reg ^ $past(clkout_reg)) & $past(run_reg)) == 4'h0)
      else $error("clock-out bit changed while running");

   a_pin_source: assert property (@(posedge ref_clk) disable iff (rst)
      (run_reg != 4'h0)
      |=> ((serial_clk_pin ^ $past(comm_clk_drive)) & $past(run_reg)) == 4'h0)
      else $error("running pin not driven by engine");

   a_code_zero: assert property (@(posedge ref_clk) disable iff (rst)
      (!clock_source_pick_reg[0] && prescaler_select_reg[3:0] == 4'h0)
      |=> operation_clock[0])
      else $error("code zero did not tick every cycle");

   a_timer_path: assert property (@(posedge ref_clk) disable iff (rst)
      (TIMER_OK && ((clock_source_pick_reg[2] ? prescaler_select_reg[7:4]
                                              : prescaler_select_reg[3:0])
                    == CODE_TIMER))
      |=> operation_clock[2] == $past(timer2_tick_pulse))
      else $error("timer pulse not passed as operation clock");

   a_bad_code: assert property (@(posedge ref_clk) disable iff (rst)
      (bad_used ##1 1'b1) |-> ##1 code_fault)
      else $error("forbidden code did not raise fault");

   c_start_stop: cover property (@(posedge ref_clk) disable iff (rst)
      wr_start ##[1:20] wr_stop);
   c_timer_clock: cover property (@(posedge ref_clk) disable iff (rst)
      operation_clock[0] && prescaler_select_reg[3:0] == 4'hF);
   c_fault_seen: cover property (@(posedge ref_clk) disable iff (rst)
      $rose(code_fault));

endmodule : serial_unit_clock_prescaler
`default_nettype wire
